//--- hw/port_mux_pkg.sv
// Package for the six-pin port with direction control and pin-function multiplexer.
// Assumes a 32-bit AXI4-Lite register bus; each register takes one aligned word.
package port_mux_pkg;
	// ***************************************************
	// Register map (byte addresses)
	// ***************************************************
	localparam logic [5:0] OFF_PORT_DATA = 6'h00;
	localparam logic [5:0] OFF_PORT_DIRECTION = 6'h04;
	localparam logic [5:0] OFF_PULL_HIGH_ENABLE = 6'h08;
	localparam logic [5:0] OFF_WAKE_ENABLE = 6'h0c;
	localparam logic [5:0] OFF_PIN_FUNCTION_SELECT_LOW = 6'h10;
	localparam logic [5:0] OFF_PIN_FUNCTION_SELECT_HIGH = 6'h14;
	localparam logic [5:0] OFF_INPUT_SOURCE_SELECT = 6'h18;
	localparam logic [5:0] OFF_POWER_CONTROL = 6'h1c;
	// ***************************************************
	// Widths and reset values
	// ***************************************************
	localparam int NUM_PINS = 6;
	localparam logic [5:0] PORT_DATA_RST = 6'h3f;
	localparam logic [5:0] PORT_DIRECTION_RST = 6'h3f;
	localparam logic [5:0] PULL_HIGH_RST = 6'h00;
	localparam logic [5:0] WAKE_RST = 6'h00;
	localparam logic [7:0] FUNC_LOW_RST = 8'h00;
	localparam logic [1:0] FUNC_HIGH_RST = 2'h0;
	localparam logic INPUT_SOURCE_RST = 1'b0;
	// ***************************************************
	// Field positions in pin_function_select_low
	// ***************************************************
	localparam int PIN0_CODE_LSB = 0;
	localparam int PIN1_CODE_LSB = 2;
	localparam int PIN2_CODE_LSB = 4;
	localparam int PIN3_CODE_LSB = 6;
	// ***************************************************
	// Function codes
	// ***************************************************
	localparam logic [1:0] CODE_ALT = 2'h1;
	localparam logic [1:0] CODE_TIMER = 2'h3;
	localparam logic [1:0] CODE_OVP_REF = 2'h2;
	// ***************************************************
	// Bus answers
	// ***************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WRITE_RESP = 3'b010,
		BUS_READ_DATA = 3'b100
	} bus_state_t;
endpackage

//--- hw/pin_func_mux.sv
// Combinational pin-function multiplexer for the six port pins.
// Assumes select codes come from registers in the same clock domain.
`timescale 1ns/10ps
module pin_func_mux import port_mux_pkg::*; (
	// Selects
	input wire logic [7:0] func_low,
	input wire logic [1:0] func_high,
	input wire logic capture_source_choice,
	// Port side
	input wire logic [5:0] port_direction,
	input wire logic [5:0] port_latch,
	input wire logic [5:0] pull_high_enable,
	input wire logic [5:0] pin_in,
	// Peripherals
	input wire logic sine_generator_output,
	input wire logic timer_compare_output,
	input wire logic overvoltage_irq_signal,
	// Results
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe,
	output logic [5:0] pull_on,
	output logic [5:0] gpio_sel,
	output logic audio_left_en,
	output logic audio_right_en,
	output logic sine_out_first,
	output logic sine_out_second,
	output logic ovp_ref_en,
	output logic timer_capture_input
);
	logic [1:0] pin0_function_code;
	logic [1:0] pin1_function_code;
	logic [1:0] pin2_function_code;
	logic [1:0] pin3_function_code;
	logic pin2_timer;

	always_comb begin
		pin0_function_code = func_low[PIN0_CODE_LSB +: 2];
		pin1_function_code = func_low[PIN1_CODE_LSB +: 2];
		pin2_function_code = func_low[PIN2_CODE_LSB +: 2];
		pin3_function_code = func_low[PIN3_CODE_LSB +: 2];
		audio_left_en = (pin0_function_code == CODE_ALT); // see R9
		audio_right_en = (pin1_function_code == CODE_ALT); // see R8
		sine_out_first = (pin2_function_code == CODE_ALT); // see R7
		pin2_timer = (pin2_function_code == CODE_TIMER); // see R7
		sine_out_second = (pin3_function_code == CODE_ALT); // see R6
		ovp_ref_en = (func_high == CODE_OVP_REF); // see R10
		gpio_sel = {1'b1, ~ovp_ref_en, ~sine_out_second, ~(sine_out_first | pin2_timer),
			~audio_right_en, ~audio_left_en};
		// Capture comes from pin 3 only while it is a port pin
		timer_capture_input = capture_source_choice ? overvoltage_irq_signal
			: (pin_in[3] & gpio_sel[3]); // see R11
	end

	genvar i;
	generate
		for (i = 0; i < NUM_PINS; i++) begin : g_pin
			always_comb begin
				if (i == 2 && pin2_timer) begin
					pin_out[i] = timer_compare_output; // see R19
					pin_oe[i] = 1'b1;
				end else if ((i == 2 && sine_out_first) || (i == 3 && sine_out_second)) begin
					pin_out[i] = sine_generator_output;
					pin_oe[i] = 1'b1;
				end else begin
					pin_out[i] = port_latch[i]; // see R2
					pin_oe[i] = gpio_sel[i] & ~port_direction[i]; // see R1
				end
				// Weak pull only on a digital input
				pull_on[i] = pull_high_enable[i] & gpio_sel[i] & port_direction[i]; // see R17
			end
		end
	endgenerate
endmodule

//--- hw/port_a_direction_and_pin_mux.sv
// Six-pin port: direction, data latch, pull-high, wake-up and pin-function selection.
// Assumes an AXI4-Lite master on aclk and pins already synchronous to aclk.
`timescale 1ns/10ps
// Notes on behaviour
// R1: Direction bit one makes pin an input
// R2: Direction bit zero drives latch push-pull
// R3: Output pins read back the latch
// R4: Direction bits 5..0 reset one, upper zero
// R5: Reset sets data latches and direction high
// R6: Pin3 code 01 routes second sine output
// R7: Pin2 01 first sine, 11 timer output
// R8: Pin1 code 01 routes right audio input
// R9: Pin0 code 01 routes left audio input
// R10: Pin4 code 10 routes overvoltage reference
// R11: Capture source pin3 or overvoltage signal
// R12: Selects reset zero, unused bits read zero
// R13: Software selects function before enabling peripheral
// R14: Bit set or clear is read-modify-write
// R15: Enabled pin falling edge wakes when asleep
// R16: Wake enables act only gpio and asleep
// R17: Pull-high only on digital input pins
// R18: Inputs sampled at read, outputs latched
// R19: Timer output overrides port latch on pin
module port_a_direction_and_pin_mux import port_mux_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite write
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Port pins
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe,
	output logic [5:0] pull_on,
	// Peripherals
	input wire logic sine_generator_output,
	input wire logic timer_compare_output,
	input wire logic overvoltage_irq_signal,
	output logic audio_left_en,
	output logic audio_right_en,
	output logic sine_out_first,
	output logic sine_out_second,
	output logic ovp_ref_en,
	output logic timer_capture_input,
	// Power
	output logic wake_up
);
	// ***************************************************
	// Registers
	// ***************************************************
	bus_state_t bus_r, bus_nxt;
	logic aw_held_r, aw_held_nxt;
	logic w_held_r, w_held_nxt;
	logic [5:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic wstrb0_r, wstrb0_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [5:0] port_data_r, port_data_nxt;
	logic [5:0] port_direction_r, port_direction_nxt;
	logic [5:0] pull_high_enable_r, pull_high_enable_nxt;
	logic [5:0] wake_enable_r, wake_enable_nxt;
	logic [7:0] func_low_r, func_low_nxt;
	logic [1:0] func_high_r, func_high_nxt;
	logic capture_source_choice_r, capture_source_choice_nxt;
	logic asleep_r, asleep_nxt;
	logic [5:0] pin_prev_r, pin_prev_nxt;
	logic wake_up_r, wake_up_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
	logic [5:0] pin_out_r, pin_oe_r, pull_on_r;
	logic audio_left_r, audio_right_r, sine_first_r, sine_second_r, ovp_ref_r, capture_r;
	// Mux results
	logic [5:0] mux_out, mux_oe, mux_pull, gpio_sel;
	logic mux_left, mux_right, mux_first, mux_second, mux_ovp, mux_capture;
	logic do_write;
	logic [7:0] read_byte;
	logic read_hit;

	// ***************************************************
	// Pin-function multiplexer
	// ***************************************************
	pin_func_mux u_mux (
		.func_low(func_low_r),
		.func_high(func_high_r),
		.capture_source_choice(capture_source_choice_r),
		.port_direction(port_direction_r),
		.port_latch(port_data_r),
		.pull_high_enable(pull_high_enable_r),
		.pin_in(pin_in),
		.sine_generator_output(sine_generator_output),
		.timer_compare_output(timer_compare_output),
		.overvoltage_irq_signal(overvoltage_irq_signal),
		.pin_out(mux_out),
		.pin_oe(mux_oe),
		.pull_on(mux_pull),
		.gpio_sel(gpio_sel),
		.audio_left_en(mux_left),
		.audio_right_en(mux_right),
		.sine_out_first(mux_first),
		.sine_out_second(mux_second),
		.ovp_ref_en(mux_ovp),
		.timer_capture_input(mux_capture)
	);

	// ***************************************************
	// Read decode
	// ***************************************************
	always_comb begin
		read_hit = 1'b1;
		read_byte = 8'h00;
		unique case (s_axi_araddr)
			// Input pins sampled now, output pins show the latch
			OFF_PORT_DATA: read_byte = {2'h0, (pin_in & port_direction_r)
				| (port_data_r & ~port_direction_r)}; // see R1 see R3 see R18
			OFF_PORT_DIRECTION: read_byte = {2'h0, port_direction_r}; // see R4
			OFF_PULL_HIGH_ENABLE: read_byte = {2'h0, pull_high_enable_r};
			OFF_WAKE_ENABLE: read_byte = {2'h0, wake_enable_r};
			OFF_PIN_FUNCTION_SELECT_LOW: read_byte = func_low_r;
			OFF_PIN_FUNCTION_SELECT_HIGH: read_byte = {6'h00, func_high_r}; // see R12
			OFF_INPUT_SOURCE_SELECT: read_byte = {7'h00, capture_source_choice_r}; // see R12
			OFF_POWER_CONTROL: read_byte = {7'h00, asleep_r};
			default: read_hit = 1'b0;
		endcase
	end

	// ***************************************************
	// Bus slave and register writes
	// ***************************************************
	always_comb begin
		bus_nxt = bus_r;
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		bresp_nxt = bresp_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		port_data_nxt = port_data_r;
		port_direction_nxt = port_direction_r;
		pull_high_enable_nxt = pull_high_enable_r;
		wake_enable_nxt = wake_enable_r;
		func_low_nxt = func_low_r;
		func_high_nxt = func_high_r;
		capture_source_choice_nxt = capture_source_choice_r;
		asleep_nxt = asleep_r;
		do_write = 1'b0;
		if (bus_r == BUS_IDLE) begin
			if (!aw_held_r && s_axi_awvalid) begin
				aw_held_nxt = 1'b1;
				awaddr_nxt = s_axi_awaddr;
			end
			if (!w_held_r && s_axi_wvalid) begin
				w_held_nxt = 1'b1;
				wdata_nxt = s_axi_wdata;
				wstrb0_nxt = s_axi_wstrb[0];
			end
		end
		unique case (bus_r)
			BUS_IDLE: begin
				if (aw_held_r && w_held_r) begin
					do_write = 1'b1;
					aw_held_nxt = 1'b0;
					w_held_nxt = 1'b0;
					bresp_nxt = RESP_OKAY;
					bus_nxt = BUS_WRITE_RESP;
				end else if (s_axi_arvalid) begin
					rdata_nxt = {24'h000000, read_byte};
					rresp_nxt = read_hit ? RESP_OKAY : RESP_SLVERR;
					bus_nxt = BUS_READ_DATA;
				end
			end
			BUS_WRITE_RESP: if (s_axi_bready) bus_nxt = BUS_IDLE;
			BUS_READ_DATA: if (s_axi_rready) bus_nxt = BUS_IDLE;
		endcase
		// Only byte lane 0 holds data; a bit set or clear is a whole-byte rewrite
		if (do_write && wstrb0_r) begin // see R14
			unique case (awaddr_r)
				OFF_PORT_DATA: port_data_nxt = wdata_r[5:0];
				OFF_PORT_DIRECTION: port_direction_nxt = wdata_r[5:0];
				OFF_PULL_HIGH_ENABLE: pull_high_enable_nxt = wdata_r[5:0];
				OFF_WAKE_ENABLE: wake_enable_nxt = wdata_r[5:0];
				OFF_PIN_FUNCTION_SELECT_LOW: func_low_nxt = wdata_r[7:0];
				OFF_PIN_FUNCTION_SELECT_HIGH: func_high_nxt = wdata_r[1:0];
				OFF_INPUT_SOURCE_SELECT: capture_source_choice_nxt = wdata_r[0];
				OFF_POWER_CONTROL: asleep_nxt = wdata_r[0];
				default: bresp_nxt = RESP_SLVERR;
			endcase
		end else if (do_write && !read_hit_w(awaddr_r)) begin
			bresp_nxt = RESP_SLVERR;
		end
		// Readies come from flops so every bus output is a clean register
		awready_nxt = (bus_nxt == BUS_IDLE) && !aw_held_nxt;
		wready_nxt = (bus_nxt == BUS_IDLE) && !w_held_nxt;
		arready_nxt = (bus_nxt == BUS_IDLE) && !(aw_held_nxt && w_held_nxt);
		// Wake ends the power-down state
		if (wake_up_r) asleep_nxt = 1'b0;
	end

	function automatic logic read_hit_w(input logic [5:0] a);
		read_hit_w = (a[1:0] == 2'h0) && (a <= OFF_POWER_CONTROL);
	endfunction

	// ***************************************************
	// Wake-up detection
	// ***************************************************
	always_comb begin
		pin_prev_nxt = pin_in;
		// Falling edge on an enabled port pin while powered down
		wake_up_nxt = asleep_r && |(pin_prev_r & ~pin_in & wake_enable_r & gpio_sel); // see R15 see R16
	end

	// ***************************************************
	// Flip-flops
	// ***************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_r <= BUS_IDLE;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 6'h00;
			wdata_r <= 32'h00000000;
			wstrb0_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
			port_data_r <= PORT_DATA_RST; // see R5
			port_direction_r <= PORT_DIRECTION_RST; // see R4 see R5
			pull_high_enable_r <= PULL_HIGH_RST;
			wake_enable_r <= WAKE_RST;
			func_low_r <= FUNC_LOW_RST; // see R12
			func_high_r <= FUNC_HIGH_RST;
			capture_source_choice_r <= INPUT_SOURCE_RST;
			asleep_r <= 1'b0;
			pin_prev_r <= 6'h3f;
			wake_up_r <= 1'b0;
			pin_out_r <= 6'h00;
			pin_oe_r <= 6'h00;
			pull_on_r <= 6'h00;
			audio_left_r <= 1'b0;
			audio_right_r <= 1'b0;
			sine_first_r <= 1'b0;
			sine_second_r <= 1'b0;
			ovp_ref_r <= 1'b0;
			capture_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else if (clk_en) begin
			bus_r <= bus_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bresp_r <= bresp_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			port_data_r <= port_data_nxt;
			port_direction_r <= port_direction_nxt;
			pull_high_enable_r <= pull_high_enable_nxt;
			wake_enable_r <= wake_enable_nxt;
			func_low_r <= func_low_nxt;
			func_high_r <= func_high_nxt;
			capture_source_choice_r <= capture_source_choice_nxt;
			asleep_r <= asleep_nxt;
			pin_prev_r <= pin_prev_nxt;
			wake_up_r <= wake_up_nxt;
			// Registered pin stage adds one cycle of latency to every route
			pin_out_r <= mux_out;
			pin_oe_r <= mux_oe;
			pull_on_r <= mux_pull;
			audio_left_r <= mux_left;
			audio_right_r <= mux_right;
			sine_first_r <= mux_first;
			sine_second_r <= mux_second;
			ovp_ref_r <= mux_ovp;
			capture_r <= mux_capture;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	// One-hot state bits are flops themselves
	assign s_axi_bvalid = bus_r[1];
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = bus_r[2];
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign pin_out = pin_out_r;
	assign pin_oe = pin_oe_r;
	assign pull_on = pull_on_r;
	assign audio_left_en = audio_left_r;
	assign audio_right_en = audio_right_r;
	assign sine_out_first = sine_first_r;
	assign sine_out_second = sine_second_r;
	assign ovp_ref_en = ovp_ref_r;
	assign timer_capture_input = capture_r;
	assign wake_up = wake_up_r;
endmodule

//--- verification/pin_partner.sv
// Model of the package pins beyond the port.
// Assumes pin_oe high while the port drives a pin.
`timescale 1ns/10ps
module pin_partner (
	// Port side
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pull_on,
	output logic [5:0] pin_in,
	// Bench side
	input wire logic [5:0] ext_level,
	input wire logic [5:0] ext_float,
	input wire logic clash
);
	// A clash is a short on the board that beats the port drive
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (pin_oe[i] && !clash)
				pin_in[i] = pin_out[i];
			else if (!ext_float[i])
				pin_in[i] = ext_level[i];
			else if (pull_on[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~pin_out[i];
		end
	end
endmodule

//--- verification/port_mux_chk.sv
// Checker for bus holds and pin routing of the port block.
// Assumes it is bound to the top module and sees its ports.
`timescale 1ns/10ps
module port_mux_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Read bus
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Pins and routes
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pull_on,
	input wire logic audio_left_en,
	input wire logic audio_right_en,
	input wire logic sine_out_first,
	input wire logic sine_out_second,
	input wire logic ovp_ref_en,
	input wire logic wake_up
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ************
	// Assertions
	// ************
	pull_excl_a: assert property ((pull_on & pin_oe) == 6'h00)
		else $error("pull-up on a driven pin");
	left_in_a: assert property (audio_left_en |-> !pin_oe[0])
		else $error("pin0 driven while audio input");
	right_in_a: assert property (audio_right_en |-> !pin_oe[1])
		else $error("pin1 driven while audio input");
	sine_one_a: assert property (sine_out_first |-> pin_oe[2])
		else $error("pin2 not driven on sine route");
	sine_two_a: assert property (sine_out_second |-> pin_oe[3])
		else $error("pin3 not driven on sine route");
	ovp_ref_a: assert property (ovp_ref_en |-> !pin_oe[4] && !pull_on[4])
		else $error("pin4 loaded while reference input");
	wake_pulse_a: assert property (wake_up |=> !wake_up)
		else $error("wake pulse longer than one cycle");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without request");
endmodule
bind port_a_direction_and_pin_mux port_mux_chk port_mux_chk_i (.*);

//--- verification/tb_top.sv
// Self-checking bench for the six-pin port block.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/10ps
module tb_top import port_mux_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clk_en = 1'b1;
	logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [5:0] pin_in, pin_out, pin_oe, pull_on;
	logic [5:0] ext_level = 6'h00, ext_float = 6'h00;
	logic clash = 1'b0, sine_generator_output = 1'b0;
	logic timer_compare_output = 1'b0, overvoltage_irq_signal = 1'b0;
	logic audio_left_en, audio_right_en, sine_out_first, sine_out_second;
	logic ovp_ref_en, timer_capture_input, wake_up;
	logic [31:0] seed = 32'h5b, v;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int n_fail = 0, n_tests = 0, cyc = 0, n_wake = 0;
	port_a_direction_and_pin_mux port_a_direction_and_pin_mux_i (.*);
	pin_partner pin_partner_i (.*);
	always #4 aclk = ~aclk;
	// ************
	// Helpers
	// ************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		bq.push_back(e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (aw || w);
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
		rq.push_back({e, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		// Late ready makes the slave hold its answer for a cycle
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	// Results are judged in arrival order against the notes
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk("read", rq.size() > 0 ? rq.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", bq.size() > 0 ? bq.pop_front() : 'x, s_axi_bresp);
		if (wake_up)
			n_wake <= n_wake + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end
	// ************
	// Tests
	// ************
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		v = rnd();
		ext_level <= v[5:0];
		rd(OFF_PORT_DIRECTION, 32'h3f, RESP_OKAY);
		rd(OFF_PIN_FUNCTION_SELECT_LOW, 32'h0, RESP_OKAY);
		rd(OFF_PIN_FUNCTION_SELECT_HIGH, 32'h0, RESP_OKAY);
		rd(OFF_PULL_HIGH_ENABLE, 32'h0, RESP_OKAY);
		rd(OFF_WAKE_ENABLE, 32'h0, RESP_OKAY);
		rd(OFF_PORT_DATA, {26'h0, v[5:0]}, RESP_OKAY);
		chk("pin_oe", 6'h00, pin_oe);
		$display("test reset done");
		wr(OFF_PORT_DIRECTION, 32'hc0, 4'h1, RESP_OKAY);
		rd(OFF_PORT_DIRECTION, 32'h0, RESP_OKAY);
		chk("pin_out", 6'h3f, pin_out);
		chk("pin_oe", 6'h3f, pin_oe);
		v = rnd();
		wr(OFF_PORT_DATA, v, 4'h1, RESP_OKAY);
		clash <= 1'b1;
		ext_level <= ~v[5:0];
		rd(OFF_PORT_DATA, {26'h0, v[5:0]}, RESP_OKAY);
		chk("pin_out", v[5:0], pin_out);
		// Bit set done by software as a whole byte
		wr(OFF_PORT_DIRECTION, 32'h08, 4'h1, RESP_OKAY);
		rd(OFF_PORT_DATA, {26'h0, v[5:4], ~v[3], v[2:0]}, RESP_OKAY);
		clash <= 1'b0;
		wr(OFF_PORT_DIRECTION, 32'h0, 4'h1, RESP_OKAY);
		$display("test direction done");
		for (int c = 0; c < 4; c++) begin
			wr(OFF_PIN_FUNCTION_SELECT_LOW, {4{c[1:0]}}, 4'h1, RESP_OKAY);
			wr(OFF_PIN_FUNCTION_SELECT_HIGH, {30'h3fffffff, c[1:0]}, 4'h1, RESP_OKAY);
			rd(OFF_PIN_FUNCTION_SELECT_HIGH, {30'h0, c[1:0]}, RESP_OKAY);
			for (int t = 0; t < 2; t++) begin
				timer_compare_output <= t[0];
				sine_generator_output <= ^rnd();
				repeat (3) @(posedge aclk);
				chk("route", {c == 1, c == 1, c == 1, c == 1, c == 2, 6'h3f & ~{1'b0, c == 2, 2'b00, c == 1, c == 1}},
					{audio_left_en, audio_right_en, sine_out_first, sine_out_second, ovp_ref_en, pin_oe});
				if (c == 3)
					chk("timer pin", t[0], pin_out[2]);
				if (c == 1)
					chk("sine pins", {2{sine_generator_output}}, pin_out[3:2]);
			end
		end
		wr(OFF_PIN_FUNCTION_SELECT_LOW, 32'h0, 4'h1, RESP_OKAY);
		wr(OFF_PORT_DIRECTION, 32'h3f, 4'h1, RESP_OKAY);
		$display("test routing done");
		for (int s = 0; s < 4; s++) begin
			ext_level <= {6{s[0]}};
			overvoltage_irq_signal <= ~s[0];
			wr(OFF_INPUT_SOURCE_SELECT, {31'h7fffffff, s[1]}, 4'h1, RESP_OKAY);
			rd(OFF_INPUT_SOURCE_SELECT, {31'h0, s[1]}, RESP_OKAY);
			chk("capture", s[1] ^ s[0], timer_capture_input);
		end
		clk_en <= 1'b0;
		overvoltage_irq_signal <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("frozen capture", 0, timer_capture_input);
		clk_en <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("capture", 1, timer_capture_input);
		overvoltage_irq_signal <= 1'b0;
		$display("test capture done");
		wr(OFF_PORT_DIRECTION, 32'h15, 4'h1, RESP_OKAY);
		wr(OFF_PULL_HIGH_ENABLE, 32'hff, 4'h1, RESP_OKAY);
		ext_float <= 6'h3f;
		rd(OFF_PULL_HIGH_ENABLE, 32'h3f, RESP_OKAY);
		rd(OFF_PORT_DATA, {26'h0, v[5:0] & 6'h2a | 6'h15}, RESP_OKAY);
		chk("pull_on", 6'h15, pull_on);
		ext_float <= 6'h00;
		wr(OFF_PULL_HIGH_ENABLE, 32'h0, 4'h0, RESP_OKAY);
		rd(OFF_PULL_HIGH_ENABLE, 32'h3f, RESP_OKAY);
		$display("test pull done");
		ext_level <= 6'h3f;
		wr(OFF_PORT_DIRECTION, 32'h3f, 4'h1, RESP_OKAY);
		wr(OFF_WAKE_ENABLE, 32'h01, 4'h1, RESP_OKAY);
		wr(OFF_POWER_CONTROL, 32'h1, 4'h1, RESP_OKAY);
		ext_level <= 6'h3d;
		repeat (4) @(posedge aclk);
		chk("wake", 0, n_wake);
		ext_level <= 6'h3c;
		repeat (4) @(posedge aclk);
		chk("wake", 1, n_wake);
		rd(OFF_POWER_CONTROL, 32'h0, RESP_OKAY);
		$display("test wake done");
		rd(6'h20, 32'h0, RESP_SLVERR);
		rd(6'h02, 32'h0, RESP_SLVERR);
		wr(6'h20, 32'hff, 4'h1, RESP_SLVERR);
		$display("test errors done");
		close_out();
	end
endmodule
